// *** hdl/pci_config_space_regs.sv ***
// configuration register set of a display controller on a pci bus
// assumes: config cycles already decoded into single-cycle strobes
// Operation
// - command bit 1 gates memory cycles; late revisions reset it to zero
// - command bit 0 gates i/o cycles; late revisions reset it to zero
// - command reads 15:10 zero, 9:0 as pattern 0010000000 at reset, 0010000011 on early revisions
// - status write of one clears that bit; writing never sets
// - status bits 10:9 report fast select timing, fixed 00
// - status bit 8 always reads zero on this target
// - interrupt line bits 3:0 writable; upper nibble zero late revisions
// - revision b upper nibble ones; revision a whole byte ones, read-only
// - interrupt pin reads one in bit 8, zeros in 15:9
// - aperture base keeps bits 31:24, reads zero in 23:0
// - base 31:30 compared with address only when linear decode set; revision b never compares
// - early rom register reads 000C0000 plus writable enable bit 0
// - later rom 31:28 writable, zero at reset; lock blocks, reads zero
// - rom at vga base when remap zero, else 256MB region repeating
// - rom enable resets zero; rom answers only with memory space set
// - moving display memory range never disables rom decoding
// - command bit 7 stepping fixed at one, ignores writes
// - parity response bit resets zero
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module pci_config_space_regs
    import cfg_space_pkg::*;
#(
    parameter rev_t REVISION = REV_D,
    parameter int ROM_WIN = `ROM_WIN_BITS
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CFG_RD,
    input wire logic CFG_WR,
    input wire logic [5:0] CFG_INDEX,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    input wire logic MEM_REQ,
    input wire logic IO_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic LIN_DECODE_EN,
    input wire logic ROM_REMAP_LOCK,
    input wire logic TARGET_ABORT,
    output logic IO_ACCEPT,
    output logic APERTURE_HIT,
    output logic ROM_HIT,
    output logic [ROM_WIN-1:0] ROM_OFFSET,
    output logic MEM_SPACE_EN,
    output logic IO_SPACE_EN,
    output logic PARITY_RESP_EN,
    output logic PALETTE_SNOOP_EN,
    output logic SPECIAL_CYCLE_EN
);
    // -----------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------
    if (ROM_WIN < 1 || ROM_WIN > 27) begin : g_bad_win
        $error("rom window width out of range");
    end

    // -----------------------------------------------------------------
    // constants
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = `CFG_OFS_CMD;
    localparam logic [7:0] OFS_BAR = `CFG_OFS_BAR;
    localparam logic [7:0] OFS_ROM = `CFG_OFS_ROM;
    localparam logic [7:0] OFS_INTL = `CFG_OFS_INTL;
    localparam logic [5:0] IDX_CMD = OFS_CMD[7:2];
    localparam logic [5:0] IDX_BAR = OFS_BAR[7:2];
    localparam logic [5:0] IDX_ROM = OFS_ROM[7:2];
    localparam logic [5:0] IDX_INTL = OFS_INTL[7:2];
    localparam logic [31:0] ROM_FIXED = `ROM_FIXED_VALUE;
    localparam bit EARLY_REV = (REVISION == REV_A) || (REVISION == REV_B);
    localparam bit ROM_REMAP_OK = (REVISION == REV_C) || (REVISION == REV_D);
    localparam logic SPACE_RST = EARLY_REV ? 1'b1 : `REG_RESET_ZERO;

    // -----------------------------------------------------------------
    // access decode
    // -----------------------------------------------------------------
    logic wr_cmd;
    logic wr_bar;
    logic wr_rom;
    logic wr_intl;
    // only config write strobes and target abort alter config register state
    assign wr_cmd = CFG_WR && (CFG_INDEX == IDX_CMD);
    assign wr_bar = CFG_WR && (CFG_INDEX == IDX_BAR);
    assign wr_rom = CFG_WR && (CFG_INDEX == IDX_ROM);
    assign wr_intl = CFG_WR && (CFG_INDEX == IDX_INTL);

    // -----------------------------------------------------------------
    // command register
    // -----------------------------------------------------------------
    logic io_en_r;
    logic mem_en_r;
    logic spc_en_r;
    logic snoop_en_r;
    logic perr_en_r;
    logic [15:0] cmd_word;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            io_en_r <= SPACE_RST;
            mem_en_r <= SPACE_RST;
        end else if (wr_cmd && CFG_BE[0]) begin
            io_en_r <= CFG_WDATA[`CMD_IO_BIT];
            mem_en_r <= CFG_WDATA[`CMD_MEM_BIT];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            spc_en_r <= 1'b0;
            snoop_en_r <= 1'b0;
            perr_en_r <= 1'b0;
        end else if (wr_cmd && CFG_BE[0]) begin
            spc_en_r <= CFG_WDATA[`CMD_SPC_BIT];
            snoop_en_r <= CFG_WDATA[`CMD_SNOOP_BIT];
            perr_en_r <= CFG_WDATA[`CMD_PERR_BIT];
        end
    end

    always_comb begin
        cmd_word = 16'h0000;
        cmd_word[`CMD_IO_BIT] = io_en_r;
        cmd_word[`CMD_MEM_BIT] = mem_en_r;
        cmd_word[`CMD_SPC_BIT] = spc_en_r;
        cmd_word[`CMD_SNOOP_BIT] = snoop_en_r;
        cmd_word[`CMD_PERR_BIT] = perr_en_r;
        cmd_word[`CMD_STEP_BIT] = 1'b1;
    end

    // -----------------------------------------------------------------
    // status register
    // -----------------------------------------------------------------
    logic tabt_r;
    logic tabt_clr;
    logic [15:0] stat_word;
    assign tabt_clr = wr_cmd && CFG_BE[3] && CFG_WDATA[16 + `STAT_TABT_BIT];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tabt_r <= 1'b0;
        end else if (TARGET_ABORT) begin
            tabt_r <= 1'b1;
        end else if (tabt_clr) begin
            tabt_r <= 1'b0;
        end
    end

    always_comb begin
        stat_word = 16'h0000;
        stat_word[`STAT_TABT_BIT] = tabt_r;
        stat_word[10:9] = `STAT_DEVSEL_FAST;
        stat_word[8] = 1'b0;
    end

    // -----------------------------------------------------------------
    // interrupt line and pin
    // -----------------------------------------------------------------
    logic [3:0] intl_r;
    logic [7:0] intl_byte;
    logic [7:0] ipin_byte;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            intl_r <= 4'h0;
        end else if (wr_intl && CFG_BE[0] && (REVISION != REV_A)) begin
            intl_r <= CFG_WDATA[3:0];
        end
    end

    always_comb begin
        if (REVISION == REV_A) begin
            intl_byte = `INTL_REV_A_VALUE;
        end else if (REVISION == REV_B) begin
            intl_byte = {`INTL_HI_REV_B, intl_r};
        end else begin
            intl_byte = {`INTL_HI_LATE, intl_r};
        end
        ipin_byte = `INT_PIN_VALUE;
    end

    // -----------------------------------------------------------------
    // linear aperture base
    // -----------------------------------------------------------------
    logic [7:0] bar_hi_r;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bar_hi_r <= 8'h00;
        end else if (wr_bar && CFG_BE[3]) begin
            bar_hi_r <= CFG_WDATA[31:24];
        end
    end

    // -----------------------------------------------------------------
    // expansion rom base
    // -----------------------------------------------------------------
    logic rom_en_r;
    logic [3:0] remap_r;
    logic [3:0] remap_eff;
    logic [31:0] rom_word;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rom_en_r <= 1'b0;
        end else if (wr_rom && CFG_BE[0]) begin
            rom_en_r <= CFG_WDATA[0];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            remap_r <= 4'h0;
        end else if (wr_rom && CFG_BE[3] && ROM_REMAP_OK && !ROM_REMAP_LOCK) begin
            remap_r <= CFG_WDATA[31:28];
        end
    end

    always_comb begin
        // lock forces zero, read and decode
        if (ROM_REMAP_OK && !ROM_REMAP_LOCK) begin
            remap_eff = remap_r;
        end else begin
            remap_eff = 4'h0;
        end
        // fixed body, enable in bit 0
        rom_word = {ROM_FIXED[31:1], rom_en_r};
        rom_word[31:28] = ROM_REMAP_OK ? remap_eff : ROM_FIXED[31:28];
    end

    // -----------------------------------------------------------------
    // config read path
    // -----------------------------------------------------------------
    logic [31:0] rd_nxt;
    logic [31:0] rdata_r;
    logic ack_r;
    always_comb begin
        if (CFG_INDEX == IDX_CMD) begin
            rd_nxt = {stat_word, cmd_word};
        end else if (CFG_INDEX == IDX_BAR) begin
            rd_nxt = {bar_hi_r, 24'h000000};
        end else if (CFG_INDEX == IDX_ROM) begin
            rd_nxt = rom_word;
        end else if (CFG_INDEX == IDX_INTL) begin
            rd_nxt = {16'h0000, ipin_byte, intl_byte};
        end else begin
            rd_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_r <= 32'h00000000;
        end else if (CFG_RD) begin
            rdata_r <= rd_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= CFG_RD | CFG_WR;
        end
    end

    assign CFG_RDATA = rdata_r;
    assign CFG_ACK = ack_r;

    // -----------------------------------------------------------------
    // memory and i/o decode
    // -----------------------------------------------------------------
    logic ap_hit;
    logic rom_hit;
    logic [ROM_WIN-1:0] rom_ofs;
    logic ap_hit_r;
    logic rom_hit_r;
    logic [ROM_WIN-1:0] rom_ofs_r;
    logic io_acc_r;

    aperture_decode #(
        .REVISION(REVISION)
    ) u_aperture (
        .mem_en(mem_en_r),
        .lin_decode_en(LIN_DECODE_EN),
        .base_top(bar_hi_r[7:6]),
        .addr_top(MEM_ADDR[31:30]),
        .hit(ap_hit)
    );

    rom_decode #(
        .WIN_BITS(ROM_WIN)
    ) u_rom (
        .mem_en(mem_en_r),
        .rom_en(rom_en_r),
        .remap(remap_eff),
        .addr(MEM_ADDR),
        .hit(rom_hit),
        .offset(rom_ofs)
    );

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ap_hit_r <= 1'b0;
            rom_hit_r <= 1'b0;
        end else begin
            ap_hit_r <= MEM_REQ & ap_hit;
            rom_hit_r <= MEM_REQ & rom_hit;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rom_ofs_r <= '0;
        end else if (MEM_REQ) begin
            rom_ofs_r <= rom_ofs;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            io_acc_r <= 1'b0;
        end else begin
            io_acc_r <= IO_REQ & io_en_r;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign APERTURE_HIT = ap_hit_r;
    assign ROM_HIT = rom_hit_r;
    assign ROM_OFFSET = rom_ofs_r;
    assign IO_ACCEPT = io_acc_r;
    assign MEM_SPACE_EN = mem_en_r;
    assign IO_SPACE_EN = io_en_r;
    assign PARITY_RESP_EN = perr_en_r;
    assign PALETTE_SNOOP_EN = snoop_en_r;
    assign SPECIAL_CYCLE_EN = spc_en_r;

endmodule : pci_config_space_regs

// *** hdl/cfg_space_cfg.svh ***
// configuration space offsets, field positions and fixed values
// assumes: included by the register set and rom decode modules
`ifndef CFG_SPACE_CFG_SVH
`define CFG_SPACE_CFG_SVH

// -----------------------------------------------------------------
// byte offsets of the configuration registers
// -----------------------------------------------------------------
`define CFG_OFS_CMD 8'h04
`define CFG_OFS_STAT 8'h06
`define CFG_OFS_BAR 8'h10
`define CFG_OFS_ROM 8'h30
`define CFG_OFS_INTL 8'h3C

// -----------------------------------------------------------------
// command register fields
// -----------------------------------------------------------------
`define CMD_IO_BIT 0
`define CMD_MEM_BIT 1
`define CMD_SPC_BIT 3
`define CMD_SNOOP_BIT 5
`define CMD_PERR_BIT 6
`define CMD_STEP_BIT 7

// -----------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------
`define STAT_TABT_BIT 11
`define STAT_DEVSEL_FAST 2'h0

// -----------------------------------------------------------------
// base, rom and interrupt fixed values
// -----------------------------------------------------------------
`define ROM_FIXED_VALUE 32'h000C0000
`define ROM_VGA_BASE 32'h000C0000
`define ROM_WIN_BITS 15
`define INTL_REV_A_VALUE 8'hFF
`define INTL_HI_REV_B 4'hF
`define INTL_HI_LATE 4'h0
`define INT_PIN_VALUE 8'h01
`define REG_RESET_ZERO 1'b0

`endif

// *** hdl/cfg_space_pkg.sv ***
// types shared by the configuration space modules
// assumes: nothing beyond the compile order
package cfg_space_pkg;

    // silicon revision selects the variant of several fields
    typedef enum logic [1:0] {
        REV_A = 2'b00,
        REV_B = 2'b01,
        REV_C = 2'b10,
        REV_D = 2'b11
    } rev_t;

endpackage : cfg_space_pkg

// *** hdl/aperture_decode.sv ***
// linear aperture hit decode for a memory address
// assumes: inputs steady within the sampling cycle
`timescale 1ns/1ps
module aperture_decode
    import cfg_space_pkg::*;
#(
    parameter rev_t REVISION = REV_D
) (
    input wire logic mem_en,
    input wire logic lin_decode_en,
    input wire logic [1:0] base_top,
    input wire logic [1:0] addr_top,
    output logic hit
);
    logic top_ok;

    always_comb begin
        if (REVISION == REV_B) begin
            top_ok = 1'b1;
        end else if (lin_decode_en) begin
            top_ok = (base_top == addr_top);
        end else begin
            top_ok = 1'b1;
        end
        hit = mem_en & lin_decode_en & top_ok;
    end

endmodule : aperture_decode

// *** hdl/rom_decode.sv ***
// expansion rom window decode for a memory address
// assumes: inputs steady within the sampling cycle
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module rom_decode
    import cfg_space_pkg::*;
#(
    parameter int WIN_BITS = `ROM_WIN_BITS
) (
    input wire logic mem_en,
    input wire logic rom_en,
    input wire logic [3:0] remap,
    input wire logic [31:0] addr,
    output logic hit,
    output logic [WIN_BITS-1:0] offset
);
    localparam logic [31:0] VGA_BASE = `ROM_VGA_BASE;
    logic in_win;

    always_comb begin
        if (remap == 4'h0) begin
            in_win = (addr[31:WIN_BITS] == VGA_BASE[31:WIN_BITS]);
        end else begin
            in_win = (addr[31:28] == remap);
        end
        hit = mem_en & rom_en & in_win;
        offset = addr[WIN_BITS-1:0];
    end

endmodule : rom_decode

// *** tb/pci_config_space_regs_monitor.sv ***
// concurrent checks on the configuration register set ports
// assumes: bound into pci_config_space_regs, one clock domain
`timescale 1ns/1ps
module cfg_space_monitor
    import cfg_space_pkg::*;
#(
    parameter rev_t REVISION = REV_D,
    parameter int ROM_WIN = 15
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CFG_RD,
    input wire logic CFG_WR,
    input wire logic [5:0] CFG_INDEX,
    input wire logic [31:0] CFG_RDATA,
    input wire logic CFG_ACK,
    input wire logic MEM_REQ,
    input wire logic IO_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic LIN_DECODE_EN,
    input wire logic ROM_REMAP_LOCK,
    input wire logic IO_ACCEPT,
    input wire logic APERTURE_HIT,
    input wire logic ROM_HIT,
    input wire logic [ROM_WIN-1:0] ROM_OFFSET,
    input wire logic MEM_SPACE_EN,
    input wire logic IO_SPACE_EN
);
    logic [ROM_WIN-1:0] addr_low;
    assign addr_low = MEM_ADDR[ROM_WIN-1:0];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // -----------------------------------------------------------
    // config bus handshake
    // -----------------------------------------------------------
    a_ack_follows_req: assert property (
        (CFG_RD || CFG_WR) |=> CFG_ACK) else $error("ack missing");
    a_ack_no_req: assert property (
        !(CFG_RD || CFG_WR) |=> !CFG_ACK) else $error("stray ack");
    a_rdata_holds: assert property (
        !CFG_RD |=> $stable(CFG_RDATA)) else $error("read data moved");

    // -----------------------------------------------------------
    // fixed read fields
    // -----------------------------------------------------------
    a_cmd_fixed_bits: assert property (
        CFG_ACK && $past(CFG_RD) && $past(CFG_INDEX) == 6'h01 |->
        CFG_RDATA[15:7] == 9'h001 && CFG_RDATA[26:24] == 3'h0 &&
        CFG_RDATA[1:0] == {MEM_SPACE_EN, IO_SPACE_EN})
        else $error("command or status fixed bits wrong");
    a_pin_fixed: assert property (
        CFG_ACK && $past(CFG_RD) && $past(CFG_INDEX) == 6'h0F |->
        CFG_RDATA[31:8] == 24'h000001) else $error("pin field wrong");
    a_base_low_zero: assert property (
        CFG_ACK && $past(CFG_RD) && $past(CFG_INDEX) == 6'h04 |->
        CFG_RDATA[23:0] == 24'h0) else $error("base low bits set");
    a_rom_fixed_bits: assert property (
        CFG_ACK && $past(CFG_RD) && $past(CFG_INDEX) == 6'h0C |->
        CFG_RDATA[27:1] == 27'h0060000 &&
        (!$past(ROM_REMAP_LOCK) || CFG_RDATA[31:28] == 4'h0))
        else $error("rom fixed bits wrong");

    // -----------------------------------------------------------
    // decode gating
    // -----------------------------------------------------------
    a_io_gated: assert property (
        IO_ACCEPT |-> $past(IO_REQ) && $past(IO_SPACE_EN))
        else $error("io accepted while disabled");
    a_io_taken: assert property (
        IO_REQ && IO_SPACE_EN |=> IO_ACCEPT) else $error("io dropped");
    a_rom_gated: assert property (
        ROM_HIT |-> $past(MEM_REQ) && $past(MEM_SPACE_EN))
        else $error("rom hit while memory off");
    a_aper_gated: assert property (
        APERTURE_HIT |-> $past(MEM_REQ) && $past(LIN_DECODE_EN) &&
        $past(MEM_SPACE_EN)) else $error("aperture hit ungated");
    a_offset_loads: assert property (
        MEM_REQ |=> ROM_OFFSET == $past(addr_low))
        else $error("rom offset wrong");

    c_rom_hit: cover property (ROM_HIT);
    c_aper_hit: cover property (APERTURE_HIT);
    c_io_accept: cover property (IO_ACCEPT);
endmodule : cfg_space_monitor

bind pci_config_space_regs cfg_space_monitor #(
    .REVISION(REVISION),
    .ROM_WIN(ROM_WIN)
) u_monitor (
    .CLK(CLK),
    .RESET(RESET),
    .CFG_RD(CFG_RD),
    .CFG_WR(CFG_WR),
    .CFG_INDEX(CFG_INDEX),
    .CFG_RDATA(CFG_RDATA),
    .CFG_ACK(CFG_ACK),
    .MEM_REQ(MEM_REQ),
    .IO_REQ(IO_REQ),
    .MEM_ADDR(MEM_ADDR),
    .LIN_DECODE_EN(LIN_DECODE_EN),
    .ROM_REMAP_LOCK(ROM_REMAP_LOCK),
    .IO_ACCEPT(IO_ACCEPT),
    .APERTURE_HIT(APERTURE_HIT),
    .ROM_HIT(ROM_HIT),
    .ROM_OFFSET(ROM_OFFSET),
    .MEM_SPACE_EN(MEM_SPACE_EN),
    .IO_SPACE_EN(IO_SPACE_EN)
);

// *** tb/cfg_host_model.sv ***
// host side model: issues configuration cycles only
// assumes: one-cycle strobes, answer one cycle later
`timescale 1ns/1ps
module cfg_host_model (
    input wire logic clk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [5:0] cfg_index,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    logic [7:0] cmp_ctl;
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_index = 6'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        cmp_ctl = 8'h00;
    end
    task automatic access(input logic wr, input logic [5:0] idx,
        input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] rd, output logic ok);
        int n;
        @(posedge clk);
        #1;
        cfg_rd = !wr;
        cfg_wr = wr;
        cfg_index = idx;
        cfg_be = be;
        cfg_wdata = wd;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_index = ~idx;
        cfg_be = 4'h0;
        cfg_wdata = ~wd;
        n = 0;
        while (cfg_ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (cfg_ack === 1'b1);
        rd = cfg_rdata;
        if (wr && idx == 6'h04 && be[3]) cmp_ctl[7:2] = wd[29:24];
    endtask : access
endmodule : cfg_host_model

// *** tb/tb_pci_config_space_regs.sv ***
// bench for the configuration register set, revisions d and b
// assumes: host model issues all config cycles
`timescale 1ns/1ps
module tb_pci_config_space_regs;
    logic clk, reset, mem_req, io_req, lin_en, rom_lock, t_abort;
    logic cfg_rd, cfg_wr, cfg_ack, io_acc, ap_hit, rom_hit;
    logic mem_en, io_en, par_en, snoop_en, spc_en;
    logic [5:0] cfg_index;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr;
    logic [14:0] rom_off;
    logic [31:0] rdata_b;
    logic ap_hit_b;
    int n_fail = 0;
    int samples_checked = 0;

    pci_config_space_regs uut (
        .CLK(clk), .RESET(reset), .CFG_RD(cfg_rd), .CFG_WR(cfg_wr),
        .CFG_INDEX(cfg_index), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack), .MEM_REQ(mem_req),
        .IO_REQ(io_req), .MEM_ADDR(mem_addr), .LIN_DECODE_EN(lin_en),
        .ROM_REMAP_LOCK(rom_lock), .TARGET_ABORT(t_abort),
        .IO_ACCEPT(io_acc), .APERTURE_HIT(ap_hit), .ROM_HIT(rom_hit),
        .ROM_OFFSET(rom_off), .MEM_SPACE_EN(mem_en), .IO_SPACE_EN(io_en),
        .PARITY_RESP_EN(par_en), .PALETTE_SNOOP_EN(snoop_en),
        .SPECIAL_CYCLE_EN(spc_en)
    );
    cfg_host_model u_host (
        .clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_index(cfg_index),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
    );
    // second copy at revision b, sharing all inputs
    pci_config_space_regs #(
        .REVISION(cfg_space_pkg::REV_B)
    ) uut_b (
        .CLK(clk), .RESET(reset), .CFG_RD(cfg_rd), .CFG_WR(cfg_wr),
        .CFG_INDEX(cfg_index), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(rdata_b), .CFG_ACK(), .MEM_REQ(mem_req),
        .IO_REQ(io_req), .MEM_ADDR(mem_addr), .LIN_DECODE_EN(lin_en),
        .ROM_REMAP_LOCK(rom_lock), .TARGET_ABORT(t_abort),
        .IO_ACCEPT(), .APERTURE_HIT(ap_hit_b), .ROM_HIT(),
        .ROM_OFFSET(), .MEM_SPACE_EN(), .IO_SPACE_EN(),
        .PARITY_RESP_EN(), .PALETTE_SNOOP_EN(), .SPECIAL_CYCLE_EN()
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        u_host.access(1'b0, idx, 4'h0, 32'h0, d, ok);
        chk({31'h0, ok}, 32'h1, "read ack");
        chk(d, exp, "read data");
    endtask : rd

    task automatic wr(input logic [5:0] idx, input logic [3:0] be,
        input logic [31:0] wd);
        logic [31:0] d;
        logic ok;
        u_host.access(1'b1, idx, be, wd, d, ok);
        chk({31'h0, ok}, 32'h1, "write ack");
    endtask : wr

    // exp is {aperture, rom, io}
    task automatic probe(input logic [31:0] a, input logic io,
        input logic [2:0] exp, input logic [14:0] off);
        @(posedge clk);
        #1;
        mem_req = !io;
        io_req = io;
        mem_addr = a;
        @(posedge clk);
        #1;
        mem_req = 1'b0;
        io_req = 1'b0;
        mem_addr = ~a;
        chk({29'h0, ap_hit, rom_hit, io_acc}, {29'h0, exp}, "decode");
        if (exp[1]) chk({17'h0, rom_off}, {17'h0, off}, "rom offset");
    endtask : probe

    initial begin
        #40000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        reset = 1'b1;
        mem_req = 1'b0;
        io_req = 1'b0;
        mem_addr = 32'h0;
        lin_en = 1'b0;
        rom_lock = 1'b0;
        t_abort = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        rd(6'h01, 32'h0000_0080);
        chk(rdata_b, 32'h0000_0083, "rev b command");
        rd(6'h04, 32'h0000_0000);
        rd(6'h0C, 32'h000C_0000);
        rd(6'h0F, 32'h0000_0100);
        chk({27'h0, par_en, snoop_en, spc_en, mem_en, io_en}, 32'h0,
            "en");
        $display("test reset done");
        wr(6'h01, 4'h3, 32'h0000_FFFF);
        rd(6'h01, 32'h0000_00EB);
        chk({27'h0, par_en, snoop_en, spc_en, mem_en, io_en}, 32'h1F,
            "en");
        @(posedge clk);
        #1 t_abort = 1'b1;
        @(posedge clk);
        #1 t_abort = 1'b0;
        rd(6'h01, 32'h0800_00EB);
        wr(6'h01, 4'h4, 32'hFFFF_FFFF);
        rd(6'h01, 32'h0800_00EB);
        wr(6'h01, 4'h8, 32'hF7FF_FFFF);
        rd(6'h01, 32'h0800_00EB);
        wr(6'h01, 4'h8, 32'h0800_0000);
        rd(6'h01, 32'h0000_00EB);
        $display("test command status done");
        probe(32'h0000_0000, 1'b1, 3'b001, 15'h0);
        wr(6'h04, 4'hF, 32'hFFFF_FFFF);
        chk({24'h0, u_host.cmp_ctl}, 32'h0000_00FC, "copy");
        rd(6'h04, 32'hFF00_0000);
        wr(6'h04, 4'h8, 32'h8000_0000);
        rd(6'h04, 32'h8000_0000);
        lin_en = 1'b1;
        probe(32'h8123_4567, 1'b0, 3'b100, 15'h0);
        probe(32'h4000_0000, 1'b0, 3'b000, 15'h0);
        chk({31'h0, ap_hit_b}, 32'h1, "rev b aperture");
        lin_en = 1'b0;
        probe(32'h8000_0000, 1'b0, 3'b000, 15'h0);
        wr(6'h0F, 4'h1, 32'hFFFF_FFFF);
        rd(6'h0F, 32'h0000_010F);
        chk(rdata_b, 32'h0000_01FF, "rev b line");
        $display("test base and line done");
        wr(6'h0C, 4'hF, 32'h3000_0001);
        rd(6'h0C, 32'h300C_0001);
        chk(rdata_b, 32'h000C_0001, "rev b rom");
        probe(32'h3000_8004, 1'b0, 3'b010, 15'h0004);
        probe(32'h4000_8004, 1'b0, 3'b000, 15'h0);
        rom_lock = 1'b1;
        rd(6'h0C, 32'h000C_0001);
        probe(32'h000C_0010, 1'b0, 3'b010, 15'h0010);
        wr(6'h0C, 4'hF, 32'h5000_0001);
        rom_lock = 1'b0;
        rd(6'h0C, 32'h300C_0001);
        wr(6'h0C, 4'hF, 32'h0000_0001);
        probe(32'h000C_7FFC, 1'b0, 3'b010, 15'h7FFC);
        probe(32'h000C_8000, 1'b0, 3'b000, 15'h0);
        $display("test rom window done");
        wr(6'h01, 4'h1, 32'h0000_0000);
        lin_en = 1'b1;
        probe(32'h000C_0000, 1'b0, 3'b000, 15'h0);
        probe(32'h0000_0000, 1'b1, 3'b000, 15'h0);
        wr(6'h01, 4'h1, 32'h0000_0002);
        wr(6'h0C, 4'h1, 32'h0000_0000);
        rd(6'h0C, 32'h000C_0000);
        probe(32'h000C_0000, 1'b0, 3'b000, 15'h0);
        wr(6'h02, 4'hF, 32'hFFFF_FFFF);
        rd(6'h02, 32'h0000_0000);
        $display("test gating done");
        conclude();
    end
endmodule : tb_pci_config_space_regs
